// ===== design/psq_params.svh
// constants for the program sequencer and memory addressing block
`ifndef PSQ_PARAMS_SVH
`define PSQ_PARAMS_SVH
`define PSQ_PC_W 14
`define PSQ_PC_RESET 14'h0000
`define PSQ_VEC_RESET 14'h0000
`define PSQ_VEC_DIV0 14'h0004
`define PSQ_VEC_TMR0 14'h0008
`define PSQ_VEC_PORTC 14'h000C
`define PSQ_VEC_DIV1 14'h0014
`define PSQ_VEC_TMR1 14'h0020
`define PSQ_STACK_DEPTH 8
`define PSQ_STACK_W 42
`define PSQ_PAGE_BIT 11
`define PSQ_ROM_AW 12
`define PSQ_TAB_W 14
`define PSQ_RAM_AW 10
`define PSQ_NIB_RESET 4'h0
`define PSQ_ROM_PAGE_MASK 4'h1
`define PSQ_BANK_MASK 4'h7
`define PSQ_IND_MASK 4'h7
`define PSQ_NUM_IRQ 5
`endif

// ===== design/psq_pkg.sv
// types shared by the program sequencer files
package psq_pkg;
  typedef enum logic [3:0] {
    PSQ_OP_NEXT = 4'h0,
    PSQ_OP_JUMP = 4'h1,
    PSQ_OP_CALL = 4'h2,
    PSQ_OP_RETURN = 4'h3,
    PSQ_OP_BRANCH = 4'h4,
    PSQ_OP_SKIP = 4'h5,
    PSQ_OP_HOLD = 4'h6
  } psq_op_t;
  typedef enum logic [3:0] {
    PSQ_REG_NONE = 4'h0,
    PSQ_REG_ROM_PAGE = 4'h1,
    PSQ_REG_IND_PAGE = 4'h2,
    PSQ_REG_WORK_PAGE = 4'h3,
    PSQ_REG_BANK = 4'h4,
    PSQ_REG_TBL_LOW = 4'h5,
    PSQ_REG_TBL_1 = 4'h6,
    PSQ_REG_TBL_2 = 4'h7,
    PSQ_REG_TBL_3 = 4'h8
  } psq_reg_t;
  typedef enum logic [1:0] {
    PSQ_RAM_DIRECT = 2'b00,
    PSQ_RAM_INDIRECT = 2'b01,
    PSQ_RAM_WORK = 2'b10
  } psq_ram_mode_t;
  typedef enum logic [1:0] {
    PSQ_ST_RUN = 2'b00,
    PSQ_ST_VECTOR = 2'b01,
    PSQ_ST_TABLE = 2'b10
  } psq_state_t;
endpackage : psq_pkg

// ===== design/psq_stack_if.sv
// push/pop carrier between the sequencer and its return stack
`timescale 1ns/1ps
`default_nettype none
interface psq_stack_if #(parameter int W = 42);
  logic push;
  logic pop;
  logic [W-1:0] push_data;
  logic [W-1:0] top_data;
  logic empty;
  modport seq (output push, output pop, output push_data, input top_data, input empty);
  modport stk (input push, input pop, input push_data, output top_data, output empty);
endinterface : psq_stack_if
`default_nettype wire

// ===== design/psq_stack.sv
// eight-level return stack that drops its oldest entry on overflow
`timescale 1ns/1ps
`default_nettype none
`include "psq_params.svh"
module psq_stack #(
  parameter int DEPTH = `PSQ_STACK_DEPTH,
  parameter int W = `PSQ_STACK_W
) (
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // sequencer side
  psq_stack_if.stk sif
);
  logic [W-1:0] mem_q [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] cnt_q;

  // entry 0 is the top; a push shifts down so the bottom falls off
  always_ff @(posedge clk) begin
    if (ce && sif.push) begin
      mem_q[0] <= sif.push_data; // R4
      for (int i = 1; i < DEPTH; i++) begin
        mem_q[i] <= mem_q[i-1]; // R7
      end
    end else if (ce && sif.pop) begin
      for (int i = 0; i < DEPTH-1; i++) begin
        mem_q[i] <= mem_q[i+1];
      end
    end
  end

  // depth saturates at eight, no overflow flag by design
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce && sif.push && cnt_q != DEPTH[$bits(cnt_q)-1:0]) begin
      cnt_q <= cnt_q + 1'b1; // R7
    end else if (ce && sif.pop && !sif.push && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign sif.top_data = mem_q[0];
  assign sif.empty = (cnt_q == '0);
endmodule : psq_stack
`default_nettype wire

// ===== design/psq_irq_pick.sv
// fixed-priority interrupt selector returning the matching vector
`timescale 1ns/1ps
`default_nettype none
`include "psq_params.svh"
module psq_irq_pick #(
  parameter int N = `PSQ_NUM_IRQ
) (
  // pending requests, bit 0 highest priority
  input wire logic [N-1:0] pending,
  // result
  output logic any,
  output logic [N-1:0] grant,
  output logic [`PSQ_PC_W-1:0] vector
);
  // lowest index wins, one grant at most
  always_comb begin
    grant = '0;
    vector = `PSQ_VEC_RESET;
    any = |pending;
    if (pending[0]) begin // R3 R22
      grant[0] = 1'b1;
      vector = `PSQ_VEC_DIV0;
    end else if (pending[1]) begin
      grant[1] = 1'b1;
      vector = `PSQ_VEC_TMR0;
    end else if (pending[2]) begin
      grant[2] = 1'b1;
      vector = `PSQ_VEC_PORTC;
    end else if (pending[3]) begin
      grant[3] = 1'b1;
      vector = `PSQ_VEC_DIV1;
    end else if (pending[4]) begin
      grant[4] = 1'b1;
      vector = `PSQ_VEC_TMR1;
    end
  end
endmodule : psq_irq_pick
`default_nettype wire

// ===== design/psq_sequencer.sv
// program counter, vectors, return stack, rom paging, table pointer and ram addressing
// Overview of operation
// R1 - 14-bit counter drives program ROM fetch
// R2 - reset or interrupt loads vector directly
// R3 - fixed vectors, first divider highest priority
// R4 - return stack: eight entries, 42 bits
// R5 - call or interrupt pushes counter automatically
// R6 - return pops top entry into counter
// R7 - ninth push drops oldest, no flag
// R8 - ROM is two 2048-word pages
// R9 - software sets page before jump/call
// R10 - branches stay inside current ROM page
// R11 - ROM readable as 16384 nibble table
// R12 - table read fetches nibble into RAM
// R13 - pointer is four nibbles, low first
// R14 - page register bit0 selects ROM page
// R15 - RAM: eight banks of 128 nibbles
// R16 - bank register low bits pick bank
// R17 - indirect page picks 16-nibble page
// R18 - work page maps sixteen pages
// R19 - other pages remain ordinary memory
// R20 - immediate operands only on work registers
// R21 - reset clears page registers and counter
// R22 - highest priority first; reserved bits zero
`timescale 1ns/1ps
`default_nettype none
`include "psq_params.svh"
module psq_sequencer #(
  parameter int PC_W = `PSQ_PC_W,
  parameter int STACK_W = `PSQ_STACK_W,
  parameter int DEPTH = `PSQ_STACK_DEPTH,
  parameter int NIRQ = `PSQ_NUM_IRQ
) (
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // decoded instruction from the core
  input wire psq_pkg::psq_op_t op,
  input wire logic [PC_W-1:0] target,
  input wire logic cond_true,
  input wire logic [STACK_W-PC_W-1:0] ctx_save,
  output logic [STACK_W-PC_W-1:0] ctx_restore,
  output logic ret_valid,
  // register moves into the page and pointer registers
  input wire psq_pkg::psq_reg_t reg_sel,
  input wire logic reg_we,
  input wire logic [3:0] reg_wdata,
  output logic [3:0] reg_rdata,
  // interrupts, bit 0 = first divider ... bit 4 = timer 1
  input wire logic [NIRQ-1:0] irq_pending,
  output logic irq_taken,
  output logic [NIRQ-1:0] irq_ack,
  // program ROM fetch
  output logic [`PSQ_ROM_AW-1:0] rom_addr,
  input wire logic [15:0] rom_data,
  // table read
  input wire logic table_read_op,
  input wire logic [6:0] table_dest,
  output logic table_busy,
  // data RAM addressing
  input wire psq_pkg::psq_ram_mode_t ram_mode,
  input wire logic [6:0] ram_direct,
  input wire logic [3:0] ram_nib,
  input wire logic imm_op,
  output logic [`PSQ_RAM_AW-1:0] ram_addr,
  output logic imm_allowed,
  output logic ram_we,
  output logic [3:0] ram_wdata,
  output logic [PC_W-1:0] instruction_pointer
);
  logic [PC_W-1:0] pc_q;
  logic [3:0] rom_page_reg_q;
  logic [3:0] ind_page_q;
  logic [3:0] work_page_reg_q;
  logic [3:0] bank_select_reg_q;
  logic [3:0] tab_q [4];
  psq_pkg::psq_state_t st_q;
  logic [6:0] tdest_q;
  logic [1:0] tsel_q;
  logic [PC_W-1:0] vec_q;
  logic any_irq;
  logic [NIRQ-1:0] grant;
  logic [PC_W-1:0] vec;
  logic [PC_W-1:0] pc_d;
  logic take_irq;
  logic [`PSQ_TAB_W-1:0] tab_addr;
  psq_stack_if #(.W(STACK_W)) sif ();

  // keep a branch target within the page of the branch itself
  function automatic logic [PC_W-1:0] in_page(input logic [PC_W-1:0] here,
                                              input logic [PC_W-1:0] tgt);
    in_page = {here[PC_W-1:`PSQ_PAGE_BIT], tgt[`PSQ_PAGE_BIT-1:0]};
  endfunction

  // jump/call target lands in the preselected page
  function automatic logic [PC_W-1:0] far_addr(input logic pg,
                                               input logic [PC_W-1:0] tgt);
    far_addr = '0;
    far_addr[`PSQ_PAGE_BIT] = pg;
    far_addr[`PSQ_PAGE_BIT-1:0] = tgt[`PSQ_PAGE_BIT-1:0];
  endfunction

  psq_stack #(.DEPTH(DEPTH), .W(STACK_W)) u_stack (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .sif(sif.stk)
  );

  psq_irq_pick #(.N(NIRQ)) u_pick (
    .pending(irq_pending),
    .any(any_irq),
    .grant(grant),
    .vector(vec)
  );

  // interrupts are taken only between instructions, never mid table read
  assign take_irq = any_irq && st_q == psq_pkg::PSQ_ST_RUN && !table_read_op; // R22
  assign irq_taken = take_irq;
  assign irq_ack = take_irq ? grant : '0; // R22

  // next program counter
  always_comb begin
    pc_d = pc_q + 1'b1;
    case (op)
      psq_pkg::PSQ_OP_JUMP: pc_d = far_addr(rom_page_reg_q[0], target); // R8 R9
      psq_pkg::PSQ_OP_CALL: pc_d = far_addr(rom_page_reg_q[0], target); // R8 R9
      psq_pkg::PSQ_OP_RETURN: pc_d = sif.top_data[PC_W-1:0]; // R6
      psq_pkg::PSQ_OP_BRANCH: pc_d = cond_true ? in_page(pc_q, target) : pc_q + 1'b1; // R10
      psq_pkg::PSQ_OP_SKIP: pc_d = cond_true ? in_page(pc_q, pc_q + 14'h0002) : pc_q + 1'b1; // R10
      psq_pkg::PSQ_OP_HOLD: pc_d = pc_q;
      default: pc_d = pc_q + 1'b1;
    endcase
  end

  // push on call or interrupt, pop on return; context rides in the upper bits
  assign sif.push = ce && ((st_q == psq_pkg::PSQ_ST_RUN && op == psq_pkg::PSQ_OP_CALL
                    && !take_irq) || take_irq); // R5 R4
  assign sif.pop = ce && st_q == psq_pkg::PSQ_ST_RUN && !take_irq
                   && op == psq_pkg::PSQ_OP_RETURN; // R6 R7
  assign sif.push_data = {ctx_save, take_irq ? pc_q : pc_q + 1'b1}; // R5
  assign ctx_restore = sif.top_data[STACK_W-1:PC_W];
  assign ret_valid = sif.pop;

  // sequencer state: run, vector load, table read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= psq_pkg::PSQ_ST_RUN;
      vec_q <= `PSQ_VEC_RESET;
      tdest_q <= '0;
      tsel_q <= '0;
    end else if (ce) begin
      case (st_q)
        psq_pkg::PSQ_ST_RUN: begin
          if (take_irq) begin
            st_q <= psq_pkg::PSQ_ST_VECTOR;
            vec_q <= vec; // R3
          end else if (table_read_op) begin
            st_q <= psq_pkg::PSQ_ST_TABLE; // R12
            tdest_q <= table_dest;
            tsel_q <= tab_addr[1:0];
          end
        end
        psq_pkg::PSQ_ST_VECTOR: st_q <= psq_pkg::PSQ_ST_RUN;
        psq_pkg::PSQ_ST_TABLE: st_q <= psq_pkg::PSQ_ST_RUN;
        default: st_q <= psq_pkg::PSQ_ST_RUN;
      endcase
    end
  end

  // program counter: reset vector, interrupt vector, or normal flow
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= `PSQ_PC_RESET; // R2 R21
    end else if (ce) begin
      if (st_q == psq_pkg::PSQ_ST_VECTOR) begin
        pc_q <= vec_q; // R2
      end else if (st_q == psq_pkg::PSQ_ST_RUN && !take_irq && !table_read_op) begin
        pc_q <= pc_d; // R1
      end else if (st_q == psq_pkg::PSQ_ST_TABLE) begin
        pc_q <= pc_q + 1'b1;
      end
    end
  end

  // page and bank registers; reserved bits are never stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rom_page_reg_q <= `PSQ_NIB_RESET; // R21
      ind_page_q <= `PSQ_NIB_RESET; // R21
      work_page_reg_q <= `PSQ_NIB_RESET; // R21
      bank_select_reg_q <= `PSQ_NIB_RESET; // R21
    end else if (ce && reg_we) begin
      case (reg_sel)
        psq_pkg::PSQ_REG_ROM_PAGE: rom_page_reg_q <= reg_wdata & `PSQ_ROM_PAGE_MASK; // R14
        psq_pkg::PSQ_REG_IND_PAGE: ind_page_q <= reg_wdata & `PSQ_IND_MASK; // R17
        psq_pkg::PSQ_REG_WORK_PAGE: work_page_reg_q <= reg_wdata; // R18
        psq_pkg::PSQ_REG_BANK: bank_select_reg_q <= reg_wdata & `PSQ_BANK_MASK; // R16
        default: ;
      endcase
    end
  end

  // table pointer nibbles; not cleared by reset, software sets them first
  always_ff @(posedge clk) begin
    if (ce && reg_we) begin
      case (reg_sel)
        psq_pkg::PSQ_REG_TBL_LOW: tab_q[0] <= reg_wdata; // R13
        psq_pkg::PSQ_REG_TBL_1: tab_q[1] <= reg_wdata; // R13
        psq_pkg::PSQ_REG_TBL_2: tab_q[2] <= reg_wdata; // R13
        psq_pkg::PSQ_REG_TBL_3: tab_q[3] <= reg_wdata; // R13
        default: ;
      endcase
    end
  end

  // table_pointer_low holds the least significant nibble of the address
  assign tab_addr = {tab_q[3][1:0], tab_q[2], tab_q[1], tab_q[0]}; // R11 R13

  // register readback, reserved bits zero
  always_comb begin
    case (reg_sel)
      psq_pkg::PSQ_REG_ROM_PAGE: reg_rdata = rom_page_reg_q; // R22
      psq_pkg::PSQ_REG_IND_PAGE: reg_rdata = ind_page_q;
      psq_pkg::PSQ_REG_WORK_PAGE: reg_rdata = work_page_reg_q;
      psq_pkg::PSQ_REG_BANK: reg_rdata = bank_select_reg_q;
      psq_pkg::PSQ_REG_TBL_LOW: reg_rdata = tab_q[0];
      psq_pkg::PSQ_REG_TBL_1: reg_rdata = tab_q[1];
      psq_pkg::PSQ_REG_TBL_2: reg_rdata = tab_q[2];
      psq_pkg::PSQ_REG_TBL_3: reg_rdata = {2'b00, tab_q[3][1:0]};
      default: reg_rdata = 4'h0;
    endcase
  end

  // during a table read the ROM word holding the nibble is fetched instead
  assign rom_addr = (st_q == psq_pkg::PSQ_ST_RUN && table_read_op)
                    ? tab_addr[`PSQ_TAB_W-1:2] : pc_q[`PSQ_ROM_AW-1:0]; // R11
  assign table_busy = (st_q == psq_pkg::PSQ_ST_TABLE);

  // table data goes to RAM in the cycle after the fetch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ram_wdata <= 4'h0;
      ram_we <= 1'b0;
    end else if (ce) begin
      ram_we <= (st_q == psq_pkg::PSQ_ST_RUN && table_read_op && !take_irq); // R12
      ram_wdata <= rom_data[{tab_addr[1:0], 2'b00} +: 4]; // R12
    end
  end

  // RAM address: bank over direct/indirect, work page in banks 0 and 1
  always_comb begin
    case (st_q == psq_pkg::PSQ_ST_TABLE ? psq_pkg::PSQ_RAM_DIRECT : ram_mode)
      psq_pkg::PSQ_RAM_INDIRECT:
        ram_addr = {bank_select_reg_q[2:0], ind_page_q[2:0], ram_nib}; // R15 R17
      psq_pkg::PSQ_RAM_WORK:
        ram_addr = {2'b00, work_page_reg_q, ram_nib}; // R18 R19
      default:
        ram_addr = {bank_select_reg_q[2:0],
                    st_q == psq_pkg::PSQ_ST_TABLE ? tdest_q : ram_direct}; // R15 R16
    endcase
  end

  // immediates combine only with working registers
  assign imm_allowed = imm_op && ram_mode == psq_pkg::PSQ_RAM_WORK; // R20

  assign instruction_pointer = pc_q; // R1
endmodule : psq_sequencer
`default_nettype wire

// ===== dv/psq_mem_model.sv
// behavioural program rom and data ram facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module psq_mem_model (
  // clock
  input wire logic clk,
  // rom fetch
  input wire logic [11:0] rom_addr,
  output logic [15:0] rom_data,
  // ram write
  input wire logic ram_we,
  input wire logic [9:0] ram_addr,
  input wire logic [3:0] ram_wdata
);
  logic [3:0] ram [1024];
  // every word distinct so a wrong fetch address shows up
  assign rom_data = {rom_addr[3:0], rom_addr ^ 12'h5A3};
  // nibble store, written only on the sequencer strobe
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
  end
endmodule // psq_mem_model
`default_nettype wire

// ===== dv/psq_seq_chk.sv
// port checker for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module psq_seq_chk #(
  parameter int PC_W = 14,
  parameter int NIRQ = 5
) (
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // instruction side
  input wire psq_pkg::psq_op_t op,
  input wire logic [PC_W-1:0] target,
  input wire logic cond_true,
  // interrupts
  input wire logic [NIRQ-1:0] irq_pending,
  input wire logic irq_taken,
  input wire logic [NIRQ-1:0] irq_ack,
  // memories
  input wire logic [11:0] rom_addr,
  input wire logic table_read_op,
  input wire logic table_busy,
  input wire logic ram_we,
  input wire psq_pkg::psq_ram_mode_t ram_mode,
  input wire logic imm_op,
  input wire logic imm_allowed,
  input wire logic ret_valid,
  input wire logic [PC_W-1:0] instruction_pointer
);
  logic vec_q;
  logic run;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the edge after an accepted interrupt only loads the vector
  always_ff @(posedge clk) begin
    vec_q <= rst_n & (ce ? irq_taken : vec_q);
  end
  assign run = ce & !irq_taken & !table_busy & !vec_q;
  // priority order of the vectors
  function automatic logic [PC_W-1:0] vec_of(input logic [NIRQ-1:0] a);
    vec_of = a[0] ? 14'h0004 : a[1] ? 14'h0008 : a[2] ? 14'h000C : a[3] ? 14'h0014 : 14'h0020;
  endfunction
  property p_rst_pc;
    $rose(rst_n) |-> instruction_pointer == '0;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("pc not zero after reset");
  property p_vec;
    irq_taken && ce ##1 ce |=> instruction_pointer == vec_of($past(irq_ack, 2));
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_prio;
    irq_taken |-> irq_ack == (irq_pending & (~irq_pending + 1'b1));
  endproperty
  a_prio: assert property (p_prio) else $error("wrong grant");
  property p_jump;
    op == psq_pkg::PSQ_OP_JUMP && run && !table_read_op |=>
      instruction_pointer[10:0] == $past(target[10:0]);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target lost");
  property p_branch;
    op == psq_pkg::PSQ_OP_BRANCH && cond_true && run && !table_read_op |=>
      instruction_pointer == {$past(instruction_pointer[PC_W-1:11]), $past(target[10:0])};
  endproperty
  a_branch: assert property (p_branch) else $error("branch left page");
  property p_table;
    table_read_op && run |=> table_busy && ram_we ##1 !table_busy;
  endproperty
  a_table: assert property (p_table) else $error("table read timing");
  property p_fetch;
    run && !table_read_op |-> rom_addr == instruction_pointer[11:0];
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address");
  property p_imm;
    imm_op |-> imm_allowed == (ram_mode == psq_pkg::PSQ_RAM_WORK);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate allowed wrongly");
  property p_ret;
    op == psq_pkg::PSQ_OP_RETURN && run |-> ret_valid;
  endproperty
  a_ret: assert property (p_ret) else $error("return did not pop");
endmodule // psq_seq_chk
bind psq_sequencer psq_seq_chk #(.PC_W(PC_W), .NIRQ(NIRQ)) u_chk (
  .clk, .rst_n, .ce, .op, .target, .cond_true, .irq_pending, .irq_taken, .irq_ack,
  .rom_addr, .table_read_op, .table_busy, .ram_we, .ram_mode, .imm_op, .imm_allowed,
  .instruction_pointer, .ret_valid
);
`default_nettype wire

// ===== dv/program_sequencer_mem_addressing_tb.sv
// self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_mem_addressing_tb;
  // stimulus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  psq_pkg::psq_op_t op = psq_pkg::PSQ_OP_HOLD;
  logic [13:0] target = '0;
  logic cond_true = 1'b0;
  logic [27:0] ctx_save = '0;
  psq_pkg::psq_reg_t reg_sel = psq_pkg::PSQ_REG_NONE;
  logic reg_we = 1'b0;
  logic [3:0] reg_wdata = '0;
  logic [4:0] irq_pending = '0;
  logic table_read_op = 1'b0;
  logic [6:0] table_dest = '0;
  psq_pkg::psq_ram_mode_t ram_mode = psq_pkg::PSQ_RAM_DIRECT;
  logic [6:0] ram_direct = '0;
  logic [3:0] ram_nib = '0;
  logic imm_op = 1'b0;
  // observed
  logic [27:0] ctx_restore;
  logic ret_valid, irq_taken, table_busy, imm_allowed, ram_we;
  logic [3:0] reg_rdata, ram_wdata;
  logic [4:0] irq_ack;
  logic [11:0] rom_addr;
  logic [15:0] rom_data;
  logic [9:0] ram_addr;
  logic [13:0] ip;
  int fail_count = 0;
  int checked = 0;
  logic [13:0] q_ret[$];
  logic [27:0] q_ctx[$];
  psq_sequencer u_dut (
    .clk, .rst_n, .ce, .op, .target, .cond_true, .ctx_save, .ctx_restore, .ret_valid,
    .reg_sel, .reg_we, .reg_wdata, .reg_rdata, .irq_pending, .irq_taken, .irq_ack,
    .rom_addr, .rom_data, .table_read_op, .table_dest, .table_busy, .ram_mode,
    .ram_direct, .ram_nib, .imm_op, .ram_addr, .imm_allowed, .ram_we, .ram_wdata,
    .instruction_pointer(ip)
  );
  psq_mem_model u_mem (.clk, .rom_addr, .rom_data, .ram_we, .ram_addr, .ram_wdata);
  // 20 mhz
  always #25 clk = ~clk;
  task automatic chk(input logic [27:0] seen, input logic [27:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // codes as in psq_op_t; an idle edge follows so op never changes twice at once
  task automatic do_op(input logic [3:0] o, input logic [13:0] t, input logic c);
    op = psq_pkg::psq_op_t'(o);
    target = t;
    cond_true = c;
    tick();
    op = psq_pkg::PSQ_OP_HOLD;
    tick();
  endtask
  // register move; select left in place for the readback
  task automatic wr(input logic [3:0] s, input logic [3:0] v);
    reg_sel = psq_pkg::psq_reg_t'(s);
    reg_wdata = v;
    reg_we = 1'b1;
    tick();
    reg_we = 1'b0;
    tick();
  endtask
  task automatic t_reset;
    chk(ip, 14'h0000, "pc reset");
    for (int i = 1; i <= 4; i++) begin
      reg_sel = psq_pkg::psq_reg_t'(i);
      tick();
      chk(reg_rdata, 4'h0, "reg reset");
    end
    $display("t_reset done");
  endtask
  task automatic t_regs;
    logic [3:0] m[4] = '{4'h1, 4'h7, 4'hF, 4'h7};
    for (int i = 0; i < 8; i++) begin
      wr(4'(i % 4 + 1), i < 4 ? 4'hF : 4'hA);
      chk(reg_rdata, m[i % 4] & (i < 4 ? 4'hF : 4'hA), "readback");
    end
    $display("t_regs done");
  endtask
  task automatic t_ram;
    imm_op = 1'b1;
    ram_direct = 7'h2A;
    ram_nib = 4'h9;
    for (int k = 0; k < 16; k++) begin
      wr(4'h3, 4'(k));
      ram_mode = psq_pkg::PSQ_RAM_WORK;
      tick();
      chk(ram_addr, {2'b00, 4'(k), 4'h9}, "work addr");
      chk(imm_allowed, 1'b1, "imm on work");
      if (k < 8) begin
        wr(4'h4, 4'(k));
        wr(4'h2, 4'(7 - k));
        ram_mode = psq_pkg::PSQ_RAM_DIRECT;
        tick();
        chk(ram_addr, {3'(k), 7'h2A}, "direct addr");
        chk(imm_allowed, 1'b0, "imm on memory");
        ram_mode = psq_pkg::PSQ_RAM_INDIRECT;
        tick();
        chk(ram_addr, {3'(k), 3'(7 - k), 4'h9}, "indirect addr");
      end
    end
    $display("t_ram done");
  endtask
  task automatic t_jump;
    wr(4'h1, 4'h1);
    do_op(4'h1, 14'h0123, 1'b0);
    chk(ip, 14'h0923, "jump page 1");
    chk(rom_addr, 12'h923, "fetch");
    do_op(4'h4, 14'h0055, 1'b1);
    chk(ip, 14'h0855, "branch");
    do_op(4'h4, 14'h0300, 1'b0);
    chk(ip, 14'h0856, "no branch");
    do_op(4'h5, 14'h0000, 1'b1);
    chk(ip, 14'h0858, "skip");
    wr(4'h1, 4'h0);
    do_op(4'h4, 14'h0010, 1'b1);
    chk(ip, 14'h0810, "branch own page");
    do_op(4'h1, 14'h0040, 1'b0);
    chk(ip, 14'h0040, "jump page 0");
    $display("t_jump done");
  endtask
  task automatic t_call;
    logic [13:0] prev = 14'h0040;
    for (int i = 0; i < 9; i++) begin
      ctx_save = 28'(i + 1);
      q_ret.push_front(prev + 14'h0001);
      q_ctx.push_front(ctx_save);
      prev = 14'h0100 + 14'(i * 16);
      do_op(4'h2, prev, 1'b0);
      chk(ip, prev, "call");
    end
    for (int i = 0; i < 8; i++) begin
      chk(ctx_restore, q_ctx.pop_front(), "stack context");
      do_op(4'h3, 14'h0000, 1'b0);
      chk(ip, q_ret.pop_front(), "return");
    end
    $display("t_call done");
  endtask
  task automatic t_irq;
    logic [13:0] v[5] = '{14'h0004, 14'h0008, 14'h000C, 14'h0014, 14'h0020};
    for (int i = 0; i < 6; i++) begin
      irq_pending = (i < 5) ? 5'(1 << i) : 5'b10110;
      tick();
      irq_pending = '0;
      tick();
      chk(ip, (i < 5) ? v[i] : v[1], "vector");
      do_op(4'h3, 14'h0000, 1'b0);
      chk(ip, 14'h0101, "resume");
    end
    $display("t_irq done");
  endtask
  task automatic t_table;
    logic [15:0] w = {4'hA, 12'hB5A ^ 12'h5A3};
    wr(4'h4, 4'h2);
    wr(4'h5, 4'h9);
    wr(4'h6, 4'h6);
    wr(4'h7, 4'hD);
    wr(4'h8, 4'h2);
    table_dest = 7'h11;
    table_read_op = 1'b1;
    tick();
    table_read_op = 1'b0;
    tick();
    tick();
    chk(u_mem.ram[10'h111], w[7:4], "table nibble");
    chk(ip, 14'h0102, "pc after table");
    $display("t_table done");
  endtask
  task automatic t_ce_reset;
    ce = 1'b0;
    op = psq_pkg::PSQ_OP_NEXT;
    tick();
    tick();
    chk(ip, 14'h0102, "frozen");
    ce = 1'b1;
    tick();
    op = psq_pkg::PSQ_OP_HOLD;
    chk(ip, 14'h0103, "count");
    rst_n = 1'b0;
    tick();
    rst_n = 1'b1;
    reg_sel = psq_pkg::PSQ_REG_BANK;
    tick();
    chk(ip, 14'h0000, "pc reset again");
    chk(reg_rdata, 4'h0, "bank reset again");
    $display("t_ce_reset done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_ram();
    t_jump();
    t_call();
    t_irq();
    t_table();
    t_ce_reset();
    tally_and_finish();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // program_sequencer_mem_addressing_tb
`default_nettype wire
